/* hdl/btg_gate_timer.sv */
// burst trigger selection, gate timing, read sequencing and duty limit
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - gate opens programmable delay after trigger
// - gate stays open programmable width
// - sixteen selectable integration rate settings
// - each read captures in-phase and quadrature
// - differential read uses two launches, 180 apart
// - rep period spaces internal launches; computer launches also wait for a request
// - source: computer, internal timer, external or manual
// - manual: with single run set, one request fires one burst; without it requests fire nothing
// - amplifier gate switches at positive crossing
// - trigger out coherent with RF and burst
// - both aux channels need separate triggers
// - duty over limit lowers rep rate
// - internal source uses deterministic hardware timer
module btg_gate_timer (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire btg_pkg::btg_cfg_s cfg,
    input wire logic cfg_load,
    input wire logic sw_trig,
    input wire logic ext_trig,
    input wire logic rf_sign,
    output logic gate_q,
    output logic amp_gate_q,
    output logic trig_out_q,
    output logic [3:0] int_rate_q,
    output btg_pkg::btg_read_s read_q,
    output logic [31:0] period_eff_q,
    output logic [31:0] ext_period_q,
    output logic busy_q,
    output logic ignored_q
);
    import btg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [2:0] ext_sy_q;
    logic [2:0] rf_sy_q;
    logic ext_lvl_q;
    logic rf_lvl_q;
    logic rf_prev_q;
    logic sw_prev_q;
    wire ext_agree = ext_sy_q[1] == ext_sy_q[2];
    wire rf_agree = rf_sy_q[1] == rf_sy_q[2];

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ext_sy_q <= 3'h0;
            rf_sy_q <= 3'h0;
            ext_lvl_q <= 1'b0;
            rf_lvl_q <= 1'b0;
            rf_prev_q <= 1'b0;
            sw_prev_q <= 1'b0;
        end else begin
            ext_sy_q <= {ext_sy_q[1:0], ext_trig};
            rf_sy_q <= {rf_sy_q[1:0], rf_sign};
            if (ext_agree) ext_lvl_q <= ext_sy_q[2];
            if (rf_agree) rf_lvl_q <= rf_sy_q[2];
            rf_prev_q <= rf_lvl_q;
            sw_prev_q <= sw_trig;
        end
    end

    wire ext_rise = ext_agree && ext_sy_q[2] && !ext_lvl_q;
    wire rf_zc = rf_lvl_q && !rf_prev_q;
    wire sw_rise = sw_trig && !sw_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // configuration latch and duty check
    btg_cfg_s cfg_q;
    logic [41:0] wid_scaled;
    logic [33:0] per_scaled;
    logic [31:0] per_fix;
    assign wid_scaled = 42'(cfg.burst_clk) * 42'(DUTY_DEN);
    assign per_scaled = 34'(cfg.period_clk) * 34'(DUTY_NUM);
    // highest rate that meets limit: period = width * 1000 / 3, rounded up
    assign per_fix = 32'((wid_scaled + 42'(DUTY_NUM) - 42'h1) / 42'(DUTY_NUM));
    wire duty_bad = wid_scaled > 42'(per_scaled);

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cfg_q <= '0;
            period_eff_q <= PERIOD_RST;
            int_rate_q <= IRATE_RST;
        end else if (cfg_load) begin
            cfg_q <= cfg;
            int_rate_q <= cfg.int_rate;
            period_eff_q <= duty_bad ? per_fix : cfg.period_clk;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // rep-rate timer and external period measure
    logic [31:0] rep_cnt_q;
    logic [31:0] ext_cnt_q;
    logic rep_armed_q;
    wire rep_src = cfg_q.src == BTG_SRC_INTERNAL
                   || cfg_q.src == BTG_SRC_COMPUTER;
    wire rep_due = rep_cnt_q >= period_eff_q - 32'h1;
    wire rep_tick = rep_src && rep_armed_q && rep_due;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rep_cnt_q <= 32'h0;
            ext_cnt_q <= 32'h0;
            ext_period_q <= 32'h0;
            rep_armed_q <= 1'b0;
        end else begin
            // a new setting drops any launch armed under the old source
            if (cfg_load) rep_armed_q <= 1'b0;
            else if (cfg_q.src == BTG_SRC_INTERNAL) rep_armed_q <= 1'b1;
            // computer source: software arms each launch by request
            else if (cfg_q.src == BTG_SRC_COMPUTER && sw_rise)
                rep_armed_q <= 1'b1;
            else if (rep_tick) rep_armed_q <= 1'b0;
            rep_cnt_q <= rep_due ? 32'h0 : rep_cnt_q + 32'h1;
            if (ext_rise) begin
                ext_period_q <= ext_cnt_q;
                ext_cnt_q <= 32'h1;
            end else if (ext_cnt_q != 32'hFFFFFFFF) begin
                ext_cnt_q <= ext_cnt_q + 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // trigger selection
    wire man_trig = cfg_q.src == BTG_SRC_MANUAL && cfg_q.single_run
                    && sw_rise;
    wire ext_sel = cfg_q.src == BTG_SRC_EXTERNAL && ext_rise;
    wire trig_req = rep_tick || man_trig || ext_sel;

    ////////////////////////////////////////////////////////////////////////
    // gate timing in 12.5 ns steps
    btg_state_e st_q;
    logic [2:0] acc_q;
    logic [18:0] step_q;
    logic half_q;
    logic aux_q;
    wire [3:0] acc_sum = {1'b0, acc_q} + {1'b0, ACC_ADD};
    // one step per 1.25 clocks: advance on 4 of every 5 clocks
    wire step_inc = acc_sum >= {1'b0, ACC_MOD};
    wire [18:0] step_nx = step_q + {18'h0, step_inc};
    wire [18:0] dly_lim = cfg_q.gate_delay < DLY_MIN_STEPS ? DLY_MIN_STEPS
                        : cfg_q.gate_delay > STEPS_MAX ? STEPS_MAX
                        : cfg_q.gate_delay;
    wire [18:0] wid_lim = cfg_q.gate_width < WID_MIN_STEPS ? WID_MIN_STEPS
                        : cfg_q.gate_width > STEPS_MAX ? STEPS_MAX
                        : cfg_q.gate_width;
    wire dly_done = step_nx >= dly_lim;
    wire wid_done = step_nx >= wid_lim;
    wire running = st_q != BTG_IDLE;
    wire [13:0] phase_now = half_q ? 14'(cfg_q.ref_phase + PHASE_HALF)
                          : cfg_q.ref_phase;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_q <= BTG_IDLE;
            acc_q <= 3'h0;
            step_q <= 19'h0;
            half_q <= 1'b0;
            aux_q <= 1'b0;
            gate_q <= 1'b0;
            amp_gate_q <= 1'b0;
            trig_out_q <= 1'b0;
            read_q <= '0;
            busy_q <= 1'b0;
            ignored_q <= 1'b0;
        end else begin
            read_q.valid <= 1'b0;
            ignored_q <= running && trig_req;
            busy_q <= running;
            acc_q <= acc_sum >= {1'b0, ACC_MOD} ? 3'(acc_sum - {1'b0, ACC_MOD})
                   : acc_sum[2:0];
            case (st_q)
                BTG_IDLE: begin
                    if (trig_req) st_q <= BTG_ARM;
                end
                BTG_ARM: begin
                    // wait for RF crossing so burst and trig out are coherent
                    if (rf_zc) begin
                        amp_gate_q <= 1'b1;
                        trig_out_q <= 1'b1;
                        acc_q <= 3'h0;
                        step_q <= 19'h0;
                        st_q <= BTG_DELAY;
                    end
                end
                BTG_DELAY: begin
                    step_q <= step_nx;
                    trig_out_q <= 1'b0;
                    if (dly_done) begin
                        gate_q <= 1'b1;
                        acc_q <= 3'h0;
                        step_q <= 19'h0;
                        st_q <= BTG_GATE;
                    end
                end
                BTG_GATE: begin
                    step_q <= step_nx;
                    if (wid_done) begin
                        gate_q <= 1'b0;
                        read_q.valid <= 1'b1;
                        read_q.phase <= phase_now;
                        read_q.second_half <= half_q;
                        read_q.aux_sel <= aux_q;
                        half_q <= cfg_q.diff_quad && !half_q;
                        if (!cfg_q.diff_quad || half_q)
                            aux_q <= cfg_q.aux_both && !aux_q;
                        st_q <= BTG_CLOSE;
                    end
                end
                BTG_CLOSE: begin
                    if (rf_zc) begin
                        amp_gate_q <= 1'b0;
                        st_q <= BTG_IDLE;
                    end
                end
                default: st_q <= BTG_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_ignore;
        @(posedge ref_clk) disable iff (!rst_b)
        (running && trig_req) |=> ignored_q;
    endproperty
    a_ignore: assert property (p_ignore) else $error("trigger not ignored");

    property p_amp_on_zc;
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(amp_gate_q) |-> $past(rf_zc);
    endproperty
    a_amp_on_zc: assert property (p_amp_on_zc) else $error("amp off crossing");

    property p_amp_off_zc;
        @(posedge ref_clk) disable iff (!rst_b)
        $fell(amp_gate_q) |-> $past(rf_zc);
    endproperty
    a_amp_off_zc: assert property (p_amp_off_zc) else $error("amp off bad");

    property p_trig_pulse;
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(trig_out_q) |-> $rose(amp_gate_q) ##1 !trig_out_q;
    endproperty
    a_trig_pulse: assert property (p_trig_pulse) else $error("trig out");

    property p_gate_inside;
        @(posedge ref_clk) disable iff (!rst_b)
        gate_q |-> amp_gate_q;
    endproperty
    a_gate_inside: assert property (p_gate_inside) else $error("gate out");

    sequence s_read;
        read_q.valid ##0 $fell(gate_q);
    endsequence
    property p_read_end;
        @(posedge ref_clk) disable iff (!rst_b)
        read_q.valid |-> s_read;
    endproperty
    a_read_end: assert property (p_read_end) else $error("read timing");

    property p_diff_phase;
        @(posedge ref_clk) disable iff (!rst_b)
        (read_q.valid && read_q.second_half)
        |-> read_q.phase == 14'(cfg_q.ref_phase + PHASE_HALF);
    endproperty
    a_diff_phase: assert property (p_diff_phase) else $error("phase");

    property p_duty;
        @(posedge ref_clk) disable iff (!rst_b)
        cfg_load |=> 42'(period_eff_q) * 42'(DUTY_NUM) >= $past(wid_scaled);
    endproperty
    a_duty: assert property (p_duty) else $error("duty limit");

    property p_rate;
        @(posedge ref_clk) disable iff (!rst_b)
        cfg_load |=> int_rate_q == $past(cfg.int_rate);
    endproperty
    a_rate: assert property (p_rate) else $error("rate");

    property p_man_single;
        @(posedge ref_clk) disable iff (!rst_b)
        (!running && cfg_q.src == BTG_SRC_MANUAL && !cfg_q.single_run
         && !rep_tick) |=> st_q != BTG_ARM;
    endproperty
    a_man_single: assert property (p_man_single) else $error("manual");

    property p_dly_min;
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(trig_out_q) |-> (!gate_q) [*8];
    endproperty
    a_dly_min: assert property (p_dly_min) else $error("gate early");

    property p_gate_min;
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(gate_q) |-> gate_q [*8];
    endproperty
    a_gate_min: assert property (p_gate_min) else $error("gate short");

    property p_rep_space;
        @(posedge ref_clk) disable iff (!rst_b)
        (rep_tick && period_eff_q > 32'h8) |=> (!rep_tick) [*8];
    endproperty
    a_rep_space: assert property (p_rep_space) else $error("rep gap");
endmodule : btg_gate_timer
`default_nettype wire

/* common/btg_pkg.sv */
// package: constants, types and states of the burst trigger gate timer
package btg_pkg;
    localparam real STEP_NS = 12.5;
    localparam real CLK_NS = 10.0;
    // delay/width counts are in 12.5 ns steps; a fine tick every step
    localparam int DLY_MIN_US_X10000 = 11125;
    localparam int WID_MIN_US_X10000 = 1125;
    localparam int MAX_US = 6550;
    localparam logic [18:0] DLY_MIN_STEPS = 19'h00059;
    localparam logic [18:0] WID_MIN_STEPS = 19'h00009;
    localparam logic [18:0] STEPS_MAX = 19'h7FEE0;
    // step generator: a 12.5 ns step is 1.25 clocks, 4 steps per 5 clocks
    localparam logic [2:0] ACC_ADD = 3'h4;
    localparam logic [2:0] ACC_MOD = 3'h5;
    localparam int RATE_HZ_LIMIT = 250;
    // duty limit 0.3 percent: width * 1000 <= period * 3
    localparam logic [9:0] DUTY_DEN = 10'h3E8;
    localparam logic [1:0] DUTY_NUM = 2'h3;
    localparam logic [31:0] PERIOD_RST = 32'h00989680;
    localparam logic [3:0] IRATE_RST = 4'h0;
    localparam logic [179:0] PH_180 = 180'h0;
    localparam logic [13:0] PHASE_HALF = 14'h2000;

    typedef enum logic [1:0] {
        BTG_SRC_COMPUTER = 2'b00,
        BTG_SRC_INTERNAL = 2'b01,
        BTG_SRC_EXTERNAL = 2'b10,
        BTG_SRC_MANUAL = 2'b11
    } btg_src_e;

    typedef enum logic [2:0] {
        BTG_IDLE = 3'b000,
        BTG_ARM = 3'b001,
        BTG_DELAY = 3'b010,
        BTG_GATE = 3'b011,
        BTG_CLOSE = 3'b100
    } btg_state_e;

    typedef struct packed {
        btg_src_e src;
        logic single_run;
        logic diff_quad;
        logic aux_both;
        logic [3:0] int_rate;
        logic [13:0] ref_phase;
        logic [18:0] gate_delay;
        logic [18:0] gate_width;
        logic [31:0] period_clk;
        logic [31:0] burst_clk;
    } btg_cfg_s;

    typedef struct packed {
        logic valid;
        logic [13:0] phase;
        logic second_half;
        logic aux_sel;
    } btg_read_s;
endpackage : btg_pkg

/* verif/btg_far_end.sv */
// far side model: rf sign comparator and external trigger source
`timescale 1ns/1ns
`default_nettype none
module btg_far_end (
    input wire logic fire,
    output logic rf_sign,
    output logic ext_trig
);
    initial begin
        rf_sign = 1'b0;
        ext_trig = 1'b0;
        #3;
        forever #50 rf_sign = ~rf_sign;
    end
    always @(posedge fire) begin
        ext_trig = 1'b1;
        #40 ext_trig = 1'b0;
    end
endmodule : btg_far_end
`default_nettype wire

/* verif/btg_gate_timer_tb_top.sv */
// self-checking bench for the burst trigger gate timer
`timescale 1ns/1ns
`default_nettype none
module btg_gate_timer_tb_top;
    import btg_pkg::*;
    logic ref_clk = 1'b0, rst_b = 1'b0, cfg_load = 1'b0, sw_trig = 1'b0;
    logic fire = 1'b0, gp = 1'b0, ap = 1'b0, rp = 1'b0;
    logic gate_q, amp_gate_q, trig_out_q, busy_q, ignored_q;
    logic [3:0] int_rate_q;
    logic [31:0] period_eff_q, ext_period_q;
    wire logic rf_sign, ext_trig;
    btg_cfg_s cfg = '0;
    btg_read_s read_q, rd[$];
    int err_total = 0, n_compared = 0, seed = 4438, now = 0, n_trig = 0;
    int n_ign = 0, rf_age = 0, gap = 0, t_trig = 0, t_open = 0, t_close = 0;
    int i, n, a, b, m, g, f;
    btg_gate_timer dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .cfg(cfg),
        .cfg_load(cfg_load), .sw_trig(sw_trig), .ext_trig(ext_trig),
        .rf_sign(rf_sign), .gate_q(gate_q), .amp_gate_q(amp_gate_q),
        .trig_out_q(trig_out_q), .int_rate_q(int_rate_q), .read_q(read_q),
        .period_eff_q(period_eff_q), .ext_period_q(ext_period_q),
        .busy_q(busy_q), .ignored_q(ignored_q));
    btg_far_end far_u (.fire(fire), .rf_sign(rf_sign), .ext_trig(ext_trig));
    always #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic near(input int got, input int s, input int lo);
        s = s < lo ? lo : s;
        // a step is 1.25 clocks; the count rounds up to whole clocks
        return got == (s * 5 + 3) / 4;
    endfunction : near
    function automatic logic [31:0] duty(input logic [31:0] p, w);
        logic [63:0] need;
        need = (64'(w) * DUTY_DEN + DUTY_NUM - 1) / DUTY_NUM;
        return 64'(w) * DUTY_DEN > 64'(p) * DUTY_NUM ? need[31:0] : p;
    endfunction : duty
    task automatic cyc(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask : cyc
    task automatic load;
        cfg_load = 1'b1;
        cyc(1);
        cfg_load = 1'b0;
        cyc(3);
    endtask : load
    task automatic poke(input logic sw);
        sw_trig = sw;
        fire = !sw;
        cyc(2);
        {sw_trig, fire} = 2'b00;
    endtask : poke
    // external trigger, then a second one inside the delay
    task automatic shoot;
        m = n_trig;
        g = n_ign;
        f = now;
        poke(1'b0);
        for (int j = 0; j < 200 && n_trig == m; j++) cyc(1);
        f = now - f;
        poke(1'b0);
        for (int j = 0; j < 9000 && busy_q !== 1'b0; j++) cyc(1);
        chk(busy_q, 1'b0);
        chk(n_trig, m + 1);
        chk(n_ign, g + 1);
        chk(ext_period_q, f);
    endtask : shoot
    always @(negedge ref_clk) begin
        now++;
        if (trig_out_q === 1'b1) begin
            n_trig++;
            gap = now - t_trig;
            t_trig = now;
            chk(amp_gate_q, 1'b1);
        end
        if (ignored_q === 1'b1) n_ign++;
        if (gate_q === 1'b1 && !gp) t_open = now;
        if (gate_q === 1'b0 && gp) begin
            t_close = now;
            chk(read_q.valid, 1'b1);
        end
        if (read_q.valid === 1'b1) rd.push_back(read_q);
        if (amp_gate_q !== ap) chk(rf_age <= 6, 1'b1);
        rf_age = (rf_sign && !rp) ? 0 : rf_age + 1;
        {gp, ap, rp} = {gate_q, amp_gate_q, rf_sign};
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        chk(period_eff_q, PERIOD_RST);
        cfg.src = BTG_SRC_EXTERNAL;
        cfg.ref_phase = 14'($random(seed));
        for (i = 0; i < 5; i++) begin
            a = i ? {$random(seed)} % 600 : 0;
            b = i ? {$random(seed)} % 300 : 9;
            cfg.gate_delay = 19'(a);
            cfg.gate_width = 19'(b);
            load;
            shoot;
            chk(near(t_open - t_trig, a, DLY_MIN_STEPS), 1'b1);
            chk(near(t_close - t_open, b, WID_MIN_STEPS), 1'b1);
            chk(rd[$].phase, cfg.ref_phase);
        end
        cfg.diff_quad = 1'b1;
        cfg.aux_both = 1'b1;
        load;
        for (i = 0; i < 4; i++) shoot;
        for (i = 0; i < 4; i++) begin
            chk(rd[5 + i].phase, 14'(cfg.ref_phase + i % 2 * PHASE_HALF));
            chk(rd[5 + i].second_half, i % 2);
            chk(rd[5 + i].aux_sel, i / 2);
        end
        for (i = 0; i < 16; i++) begin
            cfg.int_rate = 4'(i);
            load;
            chk(int_rate_q, i);
        end
        for (i = 0; i < 8; i++) begin
            cfg.period_clk = 1000 + {$random(seed)} % 100000;
            cfg.burst_clk = cfg.period_clk * 3 / 1000 + i % 3 - 1;
            load;
            chk(period_eff_q, duty(cfg.period_clk, cfg.burst_clk));
        end
        cfg.src = BTG_SRC_INTERNAL;
        cfg.period_clk = 32'h00000BB8;
        cfg.burst_clk = 32'h0000000C;
        load;
        n = n_trig + 3;
        for (i = 0; i < 15000 && n_trig < n; i++) cyc(1);
        chk(gap, duty(cfg.period_clk, cfg.burst_clk));
        for (i = 0; i < 4; i++) begin
            cfg.src = i < 3 ? BTG_SRC_MANUAL : BTG_SRC_COMPUTER;
            cfg.single_run = i != 0;
            load;
            cyc(1000);
            n = n_trig;
            poke(1'b1);
            cyc(i < 3 ? 900 : 9000);
            chk(n_trig, n + (i != 0));
        end
        conclude;
    end
    initial begin
        #800000 err_total++;
        conclude;
    end
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
endmodule : btg_gate_timer_tb_top
`default_nettype wire
